// *** verilog/cfj_unit.sv ***
// Flag-setting execution and relative jump unit with an Avalon-MM slave.
`timescale 1ns/1ps

module cfj_unit (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RSTN,
  input  wire logic                       CE,
  input  wire logic [cfj_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [31:0]                AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  output logic                            EXEC_DONE,
  output logic      [15:0]                PC_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  cfj_pkg::cfj_ctrl_t ctrl_q;
  cfj_pkg::cfj_ctrl_t ctrl_d;
  logic [15:0]        dst_q;
  logic [15:0]        dst_d;
  logic [15:0]        src_q;
  logic [15:0]        src_d;
  logic [15:0]        sr_q;
  logic [15:0]        sr_d;
  logic [15:0]        pc_q;
  logic [15:0]        pc_d;
  logic [15:0]        instr_q;
  logic [15:0]        instr_d;
  logic               taken_q;
  logic               taken_d;
  logic               ack_q;
  logic               done_q;
  logic [31:0]        rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access takes one wait state, more while CE is low, so that read
  // data is registered and a write lands on a single, known edge.
  logic        req;
  logic        accept;
  logic        wr_acc;
  logic        first;
  logic        sel_ctrl;
  logic        sel_dst;
  logic        sel_src;
  logic        sel_sr;
  logic        sel_pc;
  logic        sel_instr;
  logic [15:0] wdata;
  logic [1:0]  be;
  logic [31:0] rd_mux;

  assign req       = AVS_READ | AVS_WRITE;
  assign accept    = req & ack_q & CE;
  assign wr_acc    = AVS_WRITE & accept;
  assign first     = req & ~ack_q & CE;
  assign sel_ctrl  = AVS_ADDRESS == cfj_pkg::OFF_CTRL;
  assign sel_dst   = AVS_ADDRESS == cfj_pkg::OFF_DST;
  assign sel_src   = AVS_ADDRESS == cfj_pkg::OFF_SRC;
  assign sel_sr    = AVS_ADDRESS == cfj_pkg::OFF_SR;
  assign sel_pc    = AVS_ADDRESS == cfj_pkg::OFF_PC;
  assign sel_instr = AVS_ADDRESS == cfj_pkg::OFF_INSTR;
  assign wdata     = AVS_WRITEDATA[15:0];
  assign be        = AVS_BYTEENABLE[1:0];
  assign AVS_WAITREQUEST = req & ~(ack_q & CE);

  // Unmapped addresses read zero; the upper half word always reads zero.
  assign rd_mux =
      sel_ctrl  ? {23'h000000, taken_q, 4'h0, ctrl_q} :
      sel_dst   ? {16'h0000, dst_q} :
      sel_src   ? {16'h0000, src_q} :
      sel_sr    ? {16'h0000, sr_q & cfj_pkg::SR_MASK} :
      sel_pc    ? {16'h0000, pc_q} :
      sel_instr ? {16'h0000, instr_q} : 32'h00000000;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0]  en);
    merge = {en[1] ? nw[15:8] : old[15:8], en[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Operand views and arithmetic results.
  cfj_pkg::cfj_ctrl_t new_ctrl;
  logic               exec;
  logic               bm;
  logic [7:0]         db;
  logic [15:0]        inc_res;
  logic [15:0]        inc2_res;
  logic [15:0]        not_res;
  logic [15:0]        copy_res;

  assign new_ctrl = cfj_pkg::cfj_ctrl_t'(wdata[3:0]);
  assign exec     = wr_acc & sel_ctrl & be[0];
  assign bm       = new_ctrl.byte_mode;
  assign db       = dst_q[7:0];

  // Byte forms write the low byte and clear the high byte of the result.
  assign inc_res  = bm ? {8'h00, db + cfj_pkg::B_ONE}
                       : dst_q + cfj_pkg::W_ONE;
  assign inc2_res = bm ? {8'h00, db + cfj_pkg::B_TWO}
                       : dst_q + cfj_pkg::W_TWO;
  assign not_res  = bm ? {8'h00, db ^ cfj_pkg::B_ONES}
                       : dst_q ^ cfj_pkg::W_ONES;
  assign copy_res = bm ? {8'h00, src_q[7:0]} : src_q;

  // Sign bit picker for the active width.
  function automatic logic msb_of(input logic [15:0] v, input logic b);
    msb_of = b ? v[7] : v[15];
  endfunction : msb_of

  ////////////////////////////////////////////////////////////////////////////
  // Flag equations per operation.
  cfj_pkg::cfj_flags_t f_inc;
  cfj_pkg::cfj_flags_t f_inc2;
  cfj_pkg::cfj_flags_t f_not;
  cfj_pkg::cfj_flags_t f_old;
  logic                wrap1;
  logic                wrap2;

  assign wrap1 = bm ? db == cfj_pkg::B_ONES : dst_q == cfj_pkg::W_ONES;
  assign wrap2 = bm ? db == cfj_pkg::B_ONES_M1
                    : dst_q == cfj_pkg::W_ONES_M1;

  assign f_inc.z = wrap1;
  assign f_inc.c = wrap1;
  assign f_inc.v = bm ? db == cfj_pkg::B_MAXPOS
                      : dst_q == cfj_pkg::W_MAXPOS;
  assign f_inc.n = msb_of(inc_res, bm);

  assign f_inc2.z = wrap2;
  assign f_inc2.c = wrap1 | wrap2;
  assign f_inc2.v = bm ? (db == cfj_pkg::B_MAXPOS ||
                          db == cfj_pkg::B_MAXPOS_M1)
                       : (dst_q == cfj_pkg::W_MAXPOS ||
                          dst_q == cfj_pkg::W_MAXPOS_M1);
  assign f_inc2.n = msb_of(inc2_res, bm);

  assign f_not.z = not_res == 16'h0000;
  assign f_not.c = ~f_not.z;
  assign f_not.v = msb_of(dst_q, bm);
  assign f_not.n = msb_of(not_res, bm);

  assign f_old.v = sr_q[cfj_pkg::SR_V];
  assign f_old.n = sr_q[cfj_pkg::SR_N];
  assign f_old.z = sr_q[cfj_pkg::SR_Z];
  assign f_old.c = sr_q[cfj_pkg::SR_C];

  // Only the four arithmetic flags are rewritten, so the mode bits pass.
  function automatic logic [15:0] put_flags(input logic [15:0] sr,
                                            input cfj_pkg::cfj_flags_t f);
    logic [15:0] r;
    r = sr;
    r[cfj_pkg::SR_C] = f.c;
    r[cfj_pkg::SR_Z] = f.z;
    r[cfj_pkg::SR_N] = f.n;
    r[cfj_pkg::SR_V] = f.v;
    put_flags = r;
  endfunction : put_flags

  ////////////////////////////////////////////////////////////////////////////
  // Jump condition and target.
  cfj_pkg::cfj_cond_t cond;
  logic               take;
  logic [15:0]        ofs2;
  logic [15:0]        pc_next;
  logic [15:0]        pc_jump;

  assign cond = cfj_pkg::cfj_cond_t'(instr_q[cfj_pkg::COND_LSB +: 3]);
  assign ofs2 = {{5{instr_q[cfj_pkg::OFS_W-1]}},
                 instr_q[cfj_pkg::OFS_W-1:0], 1'b0};
  assign pc_next = pc_q + cfj_pkg::PC_STEP;
  // The offset is added to a counter that already points past the jump.
  assign pc_jump = pc_next + ofs2;

  always_comb begin
    take = 1'b0;
    unique case (cond)
      cfj_pkg::COND_NE:     take = ~f_old.z;
      cfj_pkg::COND_EQ:     take = f_old.z;
      cfj_pkg::COND_NC:     take = ~f_old.c;
      cfj_pkg::COND_C:      take = f_old.c;
      cfj_pkg::COND_N:      take = f_old.n;
      cfj_pkg::COND_GE:     take = ~(f_old.n ^ f_old.v);
      cfj_pkg::COND_L:      take = f_old.n ^ f_old.v;
      cfj_pkg::COND_ALWAYS: take = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state selection: software writes, then instruction execution.
  always_comb begin
    ctrl_d  = ctrl_q;
    dst_d   = dst_q;
    src_d   = src_q;
    sr_d    = sr_q;
    pc_d    = pc_q;
    instr_d = instr_q;
    taken_d = taken_q;
    if (wr_acc && sel_dst) begin
      dst_d = merge(dst_q, wdata, be);
    end
    if (wr_acc && sel_src) begin
      src_d = merge(src_q, wdata, be);
    end
    if (wr_acc && sel_sr) begin
      sr_d = merge(sr_q, wdata, be) & cfj_pkg::SR_MASK;
    end
    if (wr_acc && sel_pc) begin
      pc_d = merge(pc_q, wdata, be);
    end
    if (wr_acc && sel_instr) begin
      instr_d = merge(instr_q, wdata, be);
    end
    if (exec) begin
      ctrl_d = new_ctrl;
      unique case (new_ctrl.op)
        cfj_pkg::OP_INC: begin
          dst_d = inc_res;
          sr_d  = put_flags(sr_q, f_inc);
          pc_d  = pc_next;
        end
        cfj_pkg::OP_INC2: begin
          dst_d = inc2_res;
          sr_d  = put_flags(sr_q, f_inc2);
          pc_d  = pc_next;
        end
        cfj_pkg::OP_NOT: begin
          dst_d = not_res;
          sr_d  = put_flags(sr_q, f_not);
          pc_d  = pc_next;
        end
        cfj_pkg::OP_COPY: begin
          dst_d = copy_res;
          pc_d  = pc_next;
        end
        cfj_pkg::OP_NOP: begin
          // Zero moved into the constant source leaves no trace.
          pc_d  = pc_next;
        end
        cfj_pkg::OP_JUMP: begin
          pc_d    = take ? pc_jump : pc_next;
          taken_d = take;
        end
        default: begin
          // Undefined codes are recorded but change nothing else.
          ctrl_d = new_ctrl;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q  <= '0;
      dst_q   <= cfj_pkg::DATA_RST;
      src_q   <= cfj_pkg::DATA_RST;
      sr_q    <= cfj_pkg::SR_RST;
      pc_q    <= cfj_pkg::PC_RST;
      instr_q <= cfj_pkg::DATA_RST;
      taken_q <= 1'b0;
    end else if (CE) begin
      ctrl_q  <= ctrl_d;
      dst_q   <= dst_d;
      src_q   <= src_d;
      sr_q    <= sr_d;
      pc_q    <= pc_d;
      instr_q <= instr_d;
      taken_q <= taken_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q   <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (CE) begin
      ack_q  <= req & ~ack_q;
      done_q <= exec;
      if (first) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign AVS_READDATA = rdata_q;
  assign EXEC_DONE    = done_q;
  assign PC_OUT       = pc_q;

endmodule : cfj_unit

// *** verilog/cfj_pkg.sv ***
// Constants, register map and carrier types of the flag and jump unit.
package cfj_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the Avalon slave.
  localparam int unsigned ADDR_W    = 5;
  localparam logic [4:0]  OFF_CTRL  = 5'h00;
  localparam logic [4:0]  OFF_DST   = 5'h04;
  localparam logic [4:0]  OFF_SRC   = 5'h08;
  localparam logic [4:0]  OFF_SR    = 5'h0C;
  localparam logic [4:0]  OFF_PC    = 5'h10;
  localparam logic [4:0]  OFF_INSTR = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions and mask of implemented bits.
  localparam int unsigned SR_C      = 0;
  localparam int unsigned SR_Z      = 1;
  localparam int unsigned SR_N      = 2;
  localparam int unsigned SR_IE       = 3;
  localparam int unsigned SR_PROC_OFF = 4;
  localparam int unsigned SR_OSC_OFF  = 5;
  localparam int unsigned SR_V      = 8;
  localparam logic [15:0] SR_MASK   = 16'h013F;

  ////////////////////////////////////////////////////////////////////////////
  // Control and instruction fields.
  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_BYTE_BIT = 3;
  localparam int unsigned CTRL_TAKEN    = 8;
  localparam int unsigned OFS_W         = 10;
  localparam int unsigned COND_LSB      = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0] SR_RST    = 16'h0000;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operand constants.
  localparam logic [15:0] W_ONE       = 16'h0001;
  localparam logic [15:0] W_TWO       = 16'h0002;
  localparam logic [15:0] W_ONES      = 16'hFFFF;
  localparam logic [15:0] W_ONES_M1   = 16'hFFFE;
  localparam logic [15:0] W_MAXPOS    = 16'h7FFF;
  localparam logic [15:0] W_MAXPOS_M1 = 16'h7FFE;
  localparam logic [7:0]  B_ONE       = 8'h01;
  localparam logic [7:0]  B_TWO       = 8'h02;
  localparam logic [7:0]  B_ONES      = 8'hFF;
  localparam logic [7:0]  B_ONES_M1   = 8'hFE;
  localparam logic [7:0]  B_MAXPOS    = 8'h7F;
  localparam logic [7:0]  B_MAXPOS_M1 = 8'h7E;
  localparam logic [15:0] PC_STEP     = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    OP_INC, OP_INC2, OP_NOT, OP_COPY, OP_NOP, OP_JUMP
  } cfj_op_t;

  typedef enum logic [2:0] {
    COND_NE, COND_EQ, COND_NC, COND_C, COND_N, COND_GE, COND_L, COND_ALWAYS
  } cfj_cond_t;

  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } cfj_flags_t;

  typedef struct packed {
    logic    byte_mode;
    logic [2:0] op;
  } cfj_ctrl_t;

endpackage : cfj_pkg

// *** tb/cfj_unit_properties.sv ***
// Concurrent checks on the flag and jump unit's top ports.
`timescale 1ns/1ps

module cfj_unit_properties (
  input wire logic                       CORE_CLK,
  input wire logic                       RSTN,
  input wire logic                       CE,
  input wire logic [cfj_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic [31:0]                AVS_WRITEDATA,
  input wire logic [3:0]                 AVS_BYTEENABLE,
  input wire logic [31:0]                AVS_READDATA,
  input wire logic                       AVS_WAITREQUEST,
  input wire logic                       EXEC_DONE,
  input wire logic [15:0]                PC_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  logic [15:0] pc_q;
  wire         req  = AVS_READ | AVS_WRITE;
  wire         acc  = req & ~AVS_WAITREQUEST;
  wire         exec = AVS_WRITE & acc & AVS_BYTEENABLE[0]
                      & (AVS_ADDRESS == cfj_pkg::OFF_CTRL);
  wire         jump = exec & (AVS_WRITEDATA[2:0] == 3'h5);
  wire         step = exec & (AVS_WRITEDATA[2:0] < 3'h5);
  wire [15:0]  pc_d = PC_OUT - pc_q - cfj_pkg::PC_STEP;
  wire         mapped = AVS_ADDRESS inside {5'h00, 5'h04, 5'h08, 5'h0C,
                                            5'h10, 5'h14};

  // The previous counter is kept here so that jump distances need no $past.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) pc_q <= 16'h0000;
    else pc_q <= PC_OUT;
  end

  ////////////////////////////////////////
  sequence s_done_next;
    ##1 EXEC_DONE;
  endsequence
  property p_idle_nowait;
    !req |-> !AVS_WAITREQUEST;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("wait idle");
  property p_first_wait;
    acc |=> !req || AVS_WAITREQUEST;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("no wait");
  property p_one_wait;
    req && AVS_WAITREQUEST && CE |=> !req || (AVS_WAITREQUEST == !CE);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait count");
  property p_exec_done;
    exec |-> s_done_next;
  endproperty
  a_exec_done: assert property (p_exec_done) else $error("no done");
  property p_done_cause;
    $rose(EXEC_DONE) |-> $past(exec);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("stray done");
  property p_step;
    step |=> pc_d == 16'h0000;
  endproperty
  a_step: assert property (p_step) else $error("pc step");
  property p_jump;
    jump |=> !pc_d[0] && (pc_d[15:10] == 6'h00 || pc_d[15:10] == 6'h3F);
  endproperty
  a_jump: assert property (p_jump) else $error("jump range");
  property p_pc_cause;
    $changed(PC_OUT) |-> $past(exec) || $past(AVS_WRITE && acc
                                      && AVS_ADDRESS == cfj_pkg::OFF_PC);
  endproperty
  a_pc_cause: assert property (p_pc_cause) else $error("pc moved");
  property p_rd_unmapped;
    AVS_READ && acc && !mapped |-> AVS_READDATA == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
  property p_rd_hold;
    !req |=> $stable(AVS_READDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : cfj_unit_properties

bind cfj_unit cfj_unit_properties u_props (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .EXEC_DONE(EXEC_DONE), .PC_OUT(PC_OUT));

// *** tb/cfj_unit_tb_top.sv ***
// Self-checking bench of the flag and jump unit against a reference model.
`timescale 1ns/1ps

module cfj_unit_tb_top;
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        CE = 1'b1;
  logic [4:0]  AVS_ADDRESS = 5'h00;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        EXEC_DONE;
  logic [15:0] PC_OUT;
  int          miscompares = 0;
  int          compares = 0;
  int          seed = 32'h0517512E;
  logic        ce_jitter = 1'b0;
  logic [31:0] rd;
  logic [15:0] dst, src, sr, pc, ins, e_dst, e_sr, e_pc;
  logic [2:0]  op;
  logic        bm, tk;
  logic [15:0] tbl [10] = '{16'hFFFF, 16'hFFFE, 16'h7FFF, 16'h7FFE,
    16'h8000, 16'h0000, 16'h00FF, 16'h00FE, 16'h007F, 16'h007E};

  always #5 CORE_CLK = ~CORE_CLK;
  // Random enable gaps stretch the wait state without breaking the protocol.
  always @(posedge CORE_CLK) CE <= !ce_jitter || ($random(seed) & 1);

  cfj_unit dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXEC_DONE(EXEC_DONE), .PC_OUT(PC_OUT));

  ////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waitrequest and read data are read at the rising edge, before the
  // design's flops update, so they are the values that edge samples.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    int   n;
    logic w;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CORE_CLK);
      w = AVS_WAITREQUEST;
      rd = AVS_READDATA;
      n++;
    end while (w !== 1'b0 && n < 100);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (w !== 1'b0) begin
      miscompares++;
      end_sim;
    end
    @(posedge CORE_CLK);
  endtask : bus

  task automatic model;
    logic [15:0] m, h, d, r;
    logic [7:0]  t;
    logic        c, z, n, v;
    m = bm ? 16'h00FF : 16'hFFFF;
    h = bm ? 16'h0080 : 16'h8000;
    d = dst & m;
    r = d;
    {c, z, v} = {sr[0], sr[1], sr[8]};
    e_dst = dst;
    e_pc = (op > 3'h5) ? pc : pc + 16'h0002;
    t = {1'b1, sr[2] ^ sr[8], !(sr[2] ^ sr[8]), sr[2], sr[0], !sr[0],
         sr[1], !sr[1]};
    tk = (op == 3'h5) && t[ins[12:10]];
    case (op)
      3'h0: begin
        r = (d + 16'h0001) & m;
        {c, z, v} = {d == m, d == m, d == h - 16'h0001};
      end
      3'h1: begin
        r = (d + 16'h0002) & m;
        {c, z, v} = {d >= m - 16'h0001, d == m - 16'h0001,
                     d == h - 16'h0001 || d == h - 16'h0002};
      end
      3'h2: begin
        r = ~d & m;
        {c, z, v} = {r != 0, r == 0, (d & h) != 0};
      end
      3'h3: e_dst = src & m;
      default: ;
    endcase
    if (tk) e_pc = e_pc + {{5{ins[9]}}, ins[9:0], 1'b0};
    n = (op < 3'h3) ? (r & h) != 0 : sr[2];
    if (op < 3'h3) e_dst = r;
    e_sr = {sr[15:9], v, sr[7:3], n, z, c};
  endtask : model

  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    bus(1'b0, cfj_pkg::OFF_SR, 16'h0000, 4'hF);
    chk("sr reset", rd, 32'h00000000);
    bus(1'b0, cfj_pkg::OFF_PC, 16'h0000, 4'hF);
    chk("pc reset", rd, 32'h00000000);
    bus(1'b1, 5'h18, 16'hBEEF, 4'hF);
    bus(1'b0, 5'h18, 16'h0000, 4'hF);
    chk("unmapped", rd, 32'h00000000);
    bus(1'b1, cfj_pkg::OFF_DST, 16'hFFFF, 4'hF);
    bus(1'b1, cfj_pkg::OFF_DST, 16'h1234, 4'h2);
    bus(1'b0, cfj_pkg::OFF_DST, 16'h0000, 4'hF);
    chk("lane", rd, 32'h000012FF);
    for (int i = 0; i < 480; i++) begin
      op = 3'(i % 8);
      bm = 1'((i / 8) % 2);
      dst = 16'($random(seed));
      if ((i / 12) % 2 == 0)
        dst = tbl[(i / 24) % 10] ^ {dst[15:8] & {8{bm}}, 8'h00};
      src = 16'($random(seed));
      sr = 16'($random(seed)) & cfj_pkg::SR_MASK;
      pc = 16'($random(seed)) & 16'hFFFE;
      ins = 16'($random(seed));
      if (i % 18 == 5) ins[9:0] = 10'h200;
      if (i % 18 == 11) ins[9:0] = 10'h1FF;
      ce_jitter <= (i >= 360);
      model;
      bus(1'b1, cfj_pkg::OFF_DST, dst, 4'hF);
      bus(1'b1, cfj_pkg::OFF_SRC, src, 4'hF);
      bus(1'b1, cfj_pkg::OFF_SR, sr, 4'hF);
      bus(1'b1, cfj_pkg::OFF_PC, pc, 4'hF);
      bus(1'b1, cfj_pkg::OFF_INSTR, ins, 4'hF);
      bus(1'b1, cfj_pkg::OFF_CTRL, {12'h000, bm, op}, 4'hF);
      bus(1'b0, cfj_pkg::OFF_DST, 16'h0000, 4'hF);
      chk("dst", rd, {16'h0000, e_dst});
      bus(1'b0, cfj_pkg::OFF_SRC, 16'h0000, 4'hF);
      chk("src", rd, {16'h0000, src});
      bus(1'b0, cfj_pkg::OFF_SR, 16'h0000, 4'hF);
      chk("sr", rd, {16'h0000, e_sr});
      chk("flags", rd, {16'h0000, e_sr});
      chk("mode", 32'(rd[5:3]), 32'(sr[5:3]));
      chk("pc", {16'h0000, PC_OUT}, {16'h0000, e_pc});
      bus(1'b0, cfj_pkg::OFF_CTRL, 16'h0000, 4'hF);
      chk("ctrl", {28'h0000000, rd[3:0]}, {28'h0000000, bm, op});
      if (op == 3'h5) begin
        chk("taken", 32'(rd[8]), 32'(tk));
        chk("jump pc", 32'(PC_OUT), 32'(e_pc));
      end
    end
    end_sim;
  end
endmodule : cfj_unit_tb_top
